// ---- rtl/apsm_pkg.sv ----
// Shared constants for the converter peak signal monitor.
// Assumes register addresses are 15-bit serial control port addresses.
package apsm_pkg;

    localparam int unsigned SAMPLE_W  = 14;
    localparam int unsigned MAG_W     = 13;
    localparam int unsigned PERIOD_W  = 24;
    localparam int unsigned CTRL_W    = 3;
    localparam int unsigned ADDR_W    = 15;
    localparam int unsigned FRAME_W   = 25;
    localparam int unsigned SUB_W     = 5;
    localparam int unsigned PAYLOAD_W = 20;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [14:0] ADDR_MON_CTRL   = 15'h0270;
    localparam logic [14:0] ADDR_PERIOD_0   = 15'h0271;
    localparam logic [14:0] ADDR_PERIOD_1   = 15'h0272;
    localparam logic [14:0] ADDR_PERIOD_2   = 15'h0273;
    localparam logic [14:0] ADDR_HOLD_LO    = 15'h0274;
    localparam logic [14:0] ADDR_HOLD_HI    = 15'h0275;
    localparam logic [14:0] ADDR_LINK_EN_A  = 15'h0279;
    localparam logic [14:0] ADDR_LINK_EN_B  = 15'h027A;
    localparam logic [14:0] ADDR_LINK_CFG_1 = 15'h0559;
    localparam logic [14:0] ADDR_LINK_CFG_2 = 15'h055A;
    localparam logic [14:0] ADDR_LINK_CFG_3 = 15'h058F;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions and reset values
    localparam int unsigned PEAK_EN_BIT   = 1;
    localparam int unsigned LINK_EN_B_BIT = 1;
    localparam logic [2:0]  MON_SEL_CODE  = 3'h5;
    localparam logic [7:0]  REG_RESET     = 8'h00;
    localparam int unsigned SPI_INSTR_W   = 16;
    localparam int unsigned SPI_DATA_W    = 8;

endpackage : apsm_pkg

// ---- rtl/apsm_reg_if.sv ----
// Byte register access between the serial control port and the monitor.
// Assumes one clock domain; rd and wr are one-cycle pulses.
`timescale 1ns/1ps
interface apsm_reg_if;
    logic        wr;
    logic        rd;
    logic [14:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;

    modport port (output wr, output rd, output addr, output wdata, input rdata);
    modport regs (input wr, input rd, input addr, input wdata, output rdata);
endinterface : apsm_reg_if

// ---- rtl/apsm_skid_buf.sv ----
// Two-entry buffer with valid and ready on both sides.
// Assumes the drain side may stall at any time; no word is lost.
`timescale 1ns/1ps
module apsm_skid_buf #(
    parameter int unsigned WIDTH = 17
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_reset_n,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_valid,
    output logic                  o_ready,
    output logic      [WIDTH-1:0] o_data,
    output logic                  o_valid,
    input  wire logic             i_ready
);
    logic [WIDTH-1:0] mem_q [2];
    logic [WIDTH-1:0] mem_d [2];
    logic             wp_q, wp_d, rp_q, rp_d;
    logic [1:0]       cnt_q, cnt_d;
    logic             push, pop;

    always_comb begin
        push     = i_valid && (cnt_q != 2'h2);
        pop      = i_ready && (cnt_q != 2'h0);
        mem_d[0] = mem_q[0];
        mem_d[1] = mem_q[1];
        if (push) begin
            mem_d[wp_q] = i_data;
        end
        wp_d  = push ? ~wp_q : wp_q;
        rp_d  = pop ? ~rp_q : rp_q;
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            wp_q     <= 1'b0;
            rp_q     <= 1'b0;
            cnt_q    <= 2'h0;
        end else begin
            mem_q <= mem_d;
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
        end
    end

    assign o_ready = (cnt_q != 2'h2);
    assign o_valid = (cnt_q != 2'h0);
    assign o_data  = mem_q[rp_q];
endmodule : apsm_skid_buf

// ---- rtl/apsm_spi_port.sv ----
// Serial control port slave: 16-bit instruction then data bytes, streaming.
// Assumes pins are synchronous to i_clk_sys and sclk is well below clk/4.
`timescale 1ns/1ps
module apsm_spi_port (
    input  wire logic   i_clk_sys,
    input  wire logic   i_reset_n,
    input  wire logic   i_spi_sclk,
    input  wire logic   i_spi_cs_n,
    input  wire logic   i_spi_sdi,
    output logic        o_spi_sdo,
    output logic        o_spi_sdo_oe_n,
    apsm_reg_if.port    bus
);
    logic        sclk_q, sclk_d;
    logic [4:0]  bit_q, bit_d;
    logic        instr_q, instr_d;
    logic        read_q, read_d;
    logic [14:0] addr_q, addr_d;
    logic [7:0]  sh_q, sh_d;
    logic        sdo_q, sdo_d;
    logic        rise, fall, wr, rd;

    always_comb begin
        rise    = i_spi_sclk && !sclk_q && !i_spi_cs_n;
        fall    = !i_spi_sclk && sclk_q && !i_spi_cs_n;
        sclk_d  = i_spi_sclk;
        bit_d   = bit_q;
        instr_d = instr_q;
        read_d  = read_q;
        addr_d  = addr_q;
        sh_d    = sh_q;
        sdo_d   = sdo_q;
        wr      = 1'b0;
        rd      = 1'b0;
        if (i_spi_cs_n) begin
            bit_d   = 5'h00;
            instr_d = 1'b1;
            sdo_d   = 1'b0;
        end else if (rise && instr_q) begin
            {read_d, addr_d} = {addr_q, i_spi_sdi};
            bit_d = bit_q + 5'h01;
            if (bit_q == 5'h0F) begin
                instr_d = 1'b0;
                bit_d   = 5'h00;
                rd      = addr_q[14];
            end
        end else if (rise) begin
            // A read shifts only on the falling edge, or every other bit is lost
            sh_d  = read_q ? sh_q : {sh_q[6:0], i_spi_sdi};
            bit_d = bit_q + 5'h01;
            if (bit_q == 5'h07) begin
                bit_d  = 5'h00;
                addr_d = addr_q + 15'h0001;
                wr     = !read_q;
                rd     = read_q;
            end
        end else if (fall && !instr_q && read_q) begin
            sdo_d = sh_q[7];
            sh_d  = {sh_q[6:0], 1'b0};
        end
        if (rd) begin
            sh_d = bus.rdata;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sclk_q  <= 1'b0;
            bit_q   <= 5'h00;
            instr_q <= 1'b1;
            read_q  <= 1'b0;
            addr_q  <= 15'h0000;
            sh_q    <= 8'h00;
            sdo_q   <= 1'b0;
        end else begin
            sclk_q  <= sclk_d;
            bit_q   <= bit_d;
            instr_q <= instr_d;
            read_q  <= read_d;
            addr_q  <= addr_d;
            sh_q    <= sh_d;
            sdo_q   <= sdo_d;
        end
    end

    // A streaming read fetches the next byte; a write lands on the current one
    assign bus.addr    = (instr_q) ? {addr_q[13:0], i_spi_sdi} :
                         (read_q ? addr_q + 15'h0001 : addr_q);
    assign bus.wr      = wr;
    assign bus.rd      = rd;
    assign bus.wdata   = {sh_q[6:0], i_spi_sdi};
    assign o_spi_sdo      = sdo_q;
    assign o_spi_sdo_oe_n = !(!i_spi_cs_n && !instr_q && read_q);
endmodule : apsm_spi_port

// ---- rtl/apsm_monitor.sv ----
// Converter peak signal monitor: peak over a programmable period, holding
// register, framed serial copy in the top control bit of output samples.
// Assumes one sample per accepted i_sample_valid cycle and a synchronous
// serial control port.
`timescale 1ns/1ps
module apsm_monitor #(
    parameter int unsigned SAMPLE_W = apsm_pkg::SAMPLE_W
) (
    input  wire logic                             i_clk_sys,
    input  wire logic                             i_reset_n,
    input  wire logic                             i_spi_sclk,
    input  wire logic                             i_spi_cs_n,
    input  wire logic                             i_spi_sdi,
    output logic                                  o_spi_sdo,
    output logic                                  o_spi_sdo_oe_n,
    input  wire logic            [SAMPLE_W-1:0]   i_sample,
    input  wire logic                             i_sample_valid,
    output logic                                  o_sample_ready,
    output logic [SAMPLE_W+apsm_pkg::CTRL_W-1:0]  o_sample,
    output logic                                  o_sample_valid,
    input  wire logic                             i_sample_ready
);
    localparam int unsigned MW = apsm_pkg::MAG_W;
    localparam int unsigned PW = apsm_pkg::PERIOD_W;
    localparam int unsigned OW = SAMPLE_W + apsm_pkg::CTRL_W;

    apsm_reg_if bus ();

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    logic [7:0]    ctrl_q, ctrl_d;
    logic [7:0]    en_a_q, en_a_d;
    logic [7:0]    en_b_q, en_b_d;
    logic [7:0]    cfg1_q, cfg1_d;
    logic [7:0]    cfg2_q, cfg2_d;
    logic [7:0]    cfg3_q, cfg3_d;
    logic [PW-1:0] period_q, period_d;
    logic [MW-1:0] hold_q;
    logic [7:0]    rdata;

    apsm_spi_port u_spi (
        .i_clk_sys      (i_clk_sys),
        .i_reset_n      (i_reset_n),
        .i_spi_sclk     (i_spi_sclk),
        .i_spi_cs_n     (i_spi_cs_n),
        .i_spi_sdi      (i_spi_sdi),
        .o_spi_sdo      (o_spi_sdo),
        .o_spi_sdo_oe_n (o_spi_sdo_oe_n),
        .bus            (bus.port)
    );

    always_comb begin
        ctrl_d   = ctrl_q;
        en_a_d   = en_a_q;
        en_b_d   = en_b_q;
        cfg1_d   = cfg1_q;
        cfg2_d   = cfg2_q;
        cfg3_d   = cfg3_q;
        period_d = period_q;
        if (bus.wr) begin
            case (bus.addr)
                apsm_pkg::ADDR_MON_CTRL:   ctrl_d = bus.wdata;
                apsm_pkg::ADDR_PERIOD_0:   period_d[7:0]   = bus.wdata;
                apsm_pkg::ADDR_PERIOD_1:   period_d[15:8]  = bus.wdata;
                apsm_pkg::ADDR_PERIOD_2:   period_d[23:16] = bus.wdata;
                apsm_pkg::ADDR_LINK_EN_A:  en_a_d = bus.wdata;
                apsm_pkg::ADDR_LINK_EN_B:  en_b_d = bus.wdata;
                apsm_pkg::ADDR_LINK_CFG_1: cfg1_d = bus.wdata;
                apsm_pkg::ADDR_LINK_CFG_2: cfg2_d = bus.wdata;
                apsm_pkg::ADDR_LINK_CFG_3: cfg3_d = bus.wdata;
                default: ;
            endcase
        end
        // Holding register reads back over the control port
        case (bus.addr)
            apsm_pkg::ADDR_MON_CTRL:   rdata = ctrl_q;
            apsm_pkg::ADDR_PERIOD_0:   rdata = period_q[7:0];
            apsm_pkg::ADDR_PERIOD_1:   rdata = period_q[15:8];
            apsm_pkg::ADDR_PERIOD_2:   rdata = period_q[23:16];
            apsm_pkg::ADDR_HOLD_LO:    rdata = hold_q[7:0];
            apsm_pkg::ADDR_HOLD_HI:    rdata = {3'h0, hold_q[12:8]};
            apsm_pkg::ADDR_LINK_EN_A:  rdata = en_a_q;
            apsm_pkg::ADDR_LINK_EN_B:  rdata = en_b_q;
            apsm_pkg::ADDR_LINK_CFG_1: rdata = cfg1_q;
            apsm_pkg::ADDR_LINK_CFG_2: rdata = cfg2_q;
            apsm_pkg::ADDR_LINK_CFG_3: rdata = cfg3_q;
            default:                   rdata = 8'h00;
        endcase
    end
    assign bus.rdata = rdata;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_q   <= apsm_pkg::REG_RESET;
            en_a_q   <= apsm_pkg::REG_RESET;
            en_b_q   <= apsm_pkg::REG_RESET;
            cfg1_q   <= apsm_pkg::REG_RESET;
            cfg2_q   <= apsm_pkg::REG_RESET;
            cfg3_q   <= apsm_pkg::REG_RESET;
            period_q <= '0;
        end else begin
            ctrl_q   <= ctrl_d;
            en_a_q   <= en_a_d;
            en_b_q   <= en_b_d;
            cfg1_q   <= cfg1_d;
            cfg2_q   <= cfg2_d;
            cfg3_q   <= cfg3_d;
            period_q <= period_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Peak detector
    logic          accept, peak_en, peak_en_q, xfer;
    logic [PW-1:0] timer_q, timer_d;
    logic [MW-1:0] store_q, store_d, hold_d, mag, cur;
    logic          first_q, first_d;
    logic [SAMPLE_W-1:0] abs_v;

    assign peak_en = ctrl_q[apsm_pkg::PEAK_EN_BIT];

    always_comb begin
        // Full-scale negative saturates to the largest 13-bit magnitude
        abs_v = i_sample[SAMPLE_W-1] ? (~i_sample + 1'b1) : i_sample;
        mag   = abs_v[SAMPLE_W-1] ? {MW{1'b1}} : abs_v[MW-1:0];
        cur   = (first_q || mag > store_q) ? mag : store_q;
        timer_d = timer_q;
        store_d = store_q;
        first_d = first_q;
        hold_d  = hold_q;
        xfer    = 1'b0;
        if (!peak_en) begin
            timer_d = '0;
            first_d = 1'b1;
            hold_d  = '0;
        end else if (!peak_en_q) begin
            timer_d = period_q;
            first_d = 1'b1;
        end else if (accept) begin
            // A zero period behaves as one so the timer never wraps
            if (timer_q <= 24'h000001) begin
                hold_d  = cur;
                timer_d = period_q;
                first_d = 1'b1;
                xfer    = 1'b1;
            end else begin
                timer_d = timer_q - 24'h000001;
                store_d = cur;
                first_d = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            peak_en_q <= 1'b0;
            timer_q   <= '0;
            store_q   <= '0;
            first_q   <= 1'b1;
            hold_q    <= '0;
        end else begin
            peak_en_q <= peak_en;
            timer_q   <= timer_d;
            store_q   <= store_d;
            first_q   <= first_d;
            hold_q    <= hold_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame serialiser for the embedded monitor port
    logic [apsm_pkg::FRAME_W-1:0]   frame_q, frame_d, frame_new;
    logic [4:0]                     left_q, left_d;
    logic                           pend_q, pend_d, load, link_on, mon_bit;
    logic [MW-1:0]                  pval_q, pval_d;
    logic [apsm_pkg::PAYLOAD_W-1:0] payload;
    logic [1:0]                     cs;
    logic [apsm_pkg::CTRL_W-1:0]    ctrl_bits;

    assign link_on = (en_a_q[1:0] == 2'h3) && en_b_q[apsm_pkg::LINK_EN_B_BIT]
                     && (cfg1_q[2:0] == apsm_pkg::MON_SEL_CODE);
    assign payload = {7'h00, pval_q};
    assign cs      = cfg3_q[1:0];

    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_sub
            // Start bit then four payload bits, highest subframe first
            assign frame_new[apsm_pkg::SUB_W*g +: apsm_pkg::SUB_W] =
                {1'b1, payload[4*g +: 4]};
        end
    endgenerate

    always_comb begin
        load    = link_on && (left_q == 5'h00) && pend_q;
        frame_d = frame_q;
        left_d  = left_q;
        mon_bit = 1'b0;
        pval_d  = xfer ? hold_d : pval_q;
        // A new transfer wins over the pending clear of the same cycle
        pend_d  = xfer ? 1'b1 : (load ? 1'b0 : pend_q);
        if (!link_on) begin
            left_d = 5'h00;
        end else if (load) begin
            frame_d = frame_new;
            left_d  = 5'(apsm_pkg::FRAME_W);
        end else if (accept && left_q != 5'h00) begin
            mon_bit = frame_q[apsm_pkg::FRAME_W-1];
            frame_d = {frame_q[apsm_pkg::FRAME_W-2:0], 1'b0};
            left_d  = left_q - 5'h01;
        end
        // Monitor takes the most significant control bit; the rest stay zero
        ctrl_bits = (cs != 2'h0) ? {mon_bit, 2'h0} : 3'h0;
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            frame_q <= '0;
            left_q  <= 5'h00;
            pend_q  <= 1'b0;
            pval_q  <= '0;
        end else begin
            frame_q <= frame_d;
            left_q  <= left_d;
            pend_q  <= pend_d;
            pval_q  <= pval_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output path; the buffer stalls the source when the receiver stalls
    assign accept = i_sample_valid && o_sample_ready;

    apsm_skid_buf #(
        .WIDTH (OW)
    ) u_buf (
        .i_clk_sys (i_clk_sys),
        .i_reset_n (i_reset_n),
        .i_data    ({i_sample, ctrl_bits}),
        .i_valid   (i_sample_valid),
        .o_ready   (o_sample_ready),
        .o_data    (o_sample),
        .o_valid   (o_sample_valid),
        .i_ready   (i_sample_ready)
    );
endmodule : apsm_monitor

// ---- tb/apsm_chk_monitor.sv ----
// Port-level checker for the peak signal monitor top module.
// Assumes it is bound to apsm_monitor and shares its single clock domain.
`timescale 1ns/1ps
module apsm_chk #(
    parameter int unsigned SAMPLE_W = apsm_pkg::SAMPLE_W
) (
    input wire logic                               i_clk_sys,
    input wire logic                               i_reset_n,
    input wire logic                               i_spi_sclk,
    input wire logic                               i_spi_cs_n,
    input wire logic                               o_spi_sdo,
    input wire logic                               o_spi_sdo_oe_n,
    input wire logic [SAMPLE_W-1:0]                i_sample,
    input wire logic                               i_sample_valid,
    input wire logic                               o_sample_ready,
    input wire logic [SAMPLE_W+apsm_pkg::CTRL_W-1:0] o_sample,
    input wire logic                               o_sample_valid,
    input wire logic                               i_sample_ready
);
    logic       xfer;
    logic [4:0] fpos_q;
    logic [4:0] fpos_d;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    // Bit index inside the current frame; a frame opens on the first set top control bit
    assign xfer = o_sample_valid && i_sample_ready;
    always_comb begin
        fpos_d = fpos_q;
        if (xfer && fpos_q != 5'h00) begin
            fpos_d = (fpos_q == 5'h18) ? 5'h00 : fpos_q + 5'h01;
        end else if (xfer && o_sample[2]) begin
            fpos_d = 5'h01;
        end
    end
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fpos_q <= 5'h00;
        end else begin
            fpos_q <= fpos_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    hold_stall_a: assert property (o_sample_valid && !i_sample_ready |=> o_sample_valid && $stable(o_sample))
        else $error("output word lost or changed under stall");
    full_valid_a: assert property (!o_sample_ready |-> o_sample_valid)
        else $error("buffer refuses while empty");
    empty_ready_a: assert property (!o_sample_valid |-> o_sample_ready)
        else $error("empty buffer not ready");
    pass_through_a: assert property (i_sample_valid && o_sample_ready && !o_sample_valid
        |=> o_sample_valid && o_sample[SAMPLE_W+2:3] == $past(i_sample))
        else $error("accepted sample not presented next cycle");
    sdo_idle_a: assert property (i_spi_cs_n |-> o_spi_sdo_oe_n)
        else $error("serial output driven while deselected");
    sdo_fall_a: assert property (!o_spi_sdo_oe_n && $changed(o_spi_sdo) |-> !i_spi_sclk)
        else $error("serial output changed while clock high");
    frame_start_a: assert property (xfer && fpos_q != 5'h00 && fpos_q % 5 == 0 |-> o_sample[2])
        else $error("subframe without start bit");
    zero_fill_a: assert property (xfer && fpos_q inside {[5'h01:5'h04], [5'h06:5'h08]}
        |-> !o_sample[2])
        else $error("unused payload bit not zero");
endmodule : apsm_chk

bind apsm_monitor apsm_chk #(.SAMPLE_W(SAMPLE_W)) u_chk (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_spi_sclk(i_spi_sclk),
    .i_spi_cs_n(i_spi_cs_n), .o_spi_sdo(o_spi_sdo), .o_spi_sdo_oe_n(o_spi_sdo_oe_n),
    .i_sample(i_sample), .i_sample_valid(i_sample_valid), .o_sample_ready(o_sample_ready),
    .o_sample(o_sample), .o_sample_valid(o_sample_valid), .i_sample_ready(i_sample_ready));

// ---- tb/apsm_rx_model.sv ----
// Downstream link receiver: takes output samples, stalls at random when asked,
// and rebuilds the 25-bit monitor frame from the top control bit.
`timescale 1ns/1ps
module apsm_rx_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset_n,
    input  wire logic [16:0] i_sample,
    input  wire logic        i_valid,
    input  wire logic        i_stall_en,
    output logic             o_ready,
    output logic             o_done,
    output logic [12:0]      o_peak,
    output logic             o_ok
);
    int          pos;
    logic [24:0] sh;

    initial o_ready = 1'b1;
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pos = 0;
            o_ready <= 1'b1;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_valid && o_ready) begin
                sh = {sh[23:0], i_sample[2]};
                if (pos != 0 || i_sample[2]) begin
                    pos++;
                end
                if (pos == 25) begin
                    pos = 0;
                    o_done <= 1'b1;
                    o_peak <= {sh[15], sh[13:10], sh[8:5], sh[3:0]};
                    o_ok <= sh[24] & sh[19] & sh[14] & sh[9] & sh[4];
                end
            end
            o_ready <= i_stall_en ? ($urandom % 3 != 0) : 1'b1;
        end
    end
endmodule : apsm_rx_model

// ---- tb/adc_peak_signal_monitor_tb.sv ----
// Self-checking bench: registers over the serial port, random sample stream,
// frame content against a peak model. Assumes apsm_chk is bound to the design.
`timescale 1ns/1ps
module adc_peak_signal_monitor_tb;
    localparam int LIMIT = 20000;
    logic        i_clk_sys, i_reset_n, i_spi_sclk, i_spi_cs_n, i_spi_sdi;
    logic        o_spi_sdo, o_spi_sdo_oe_n, o_sample_ready, o_sample_valid, i_sample_ready;
    logic [13:0] i_sample;
    logic        i_sample_valid, stall_en, done, f_ok, run, cmp;
    logic [16:0] o_sample;
    logic [12:0] f_peak, m, run_max, last_peak;
    logic [7:0]  rb;
    int          fails, check_count, cyc, cnt, per, nper, lim, nfr;
    logic [12:0] exp_q[$];

    apsm_monitor dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_spi_sclk(i_spi_sclk),
        .i_spi_cs_n(i_spi_cs_n), .i_spi_sdi(i_spi_sdi), .o_spi_sdo(o_spi_sdo),
        .o_spi_sdo_oe_n(o_spi_sdo_oe_n), .i_sample(i_sample), .i_sample_valid(i_sample_valid),
        .o_sample_ready(o_sample_ready), .o_sample(o_sample), .o_sample_valid(o_sample_valid),
        .i_sample_ready(i_sample_ready));
    apsm_rx_model rx (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_sample(o_sample),
        .i_valid(o_sample_valid), .i_stall_en(stall_en), .o_ready(i_sample_ready),
        .o_done(done), .o_peak(f_peak), .o_ok(f_ok));

    initial begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [12:0] mag(input logic [13:0] s);
        if (s == 14'h2000) return 13'h1FFF;
        return s[13] ? 13'(-s) : s[12:0];
    endfunction : mag

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_reg

    task automatic chk_val(input logic [12:0] got, input logic [12:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_val

    // Mode 0, four clocks per sclk level, MSB first
    task automatic spi(input logic rd, input logic [14:0] a, input logic [7:0] wd);
        logic [23:0] w;
        w = {rd, a, wd};
        @(posedge i_clk_sys) i_spi_cs_n <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            @(posedge i_clk_sys) i_spi_sclk <= 1'b0;
            i_spi_sdi <= w[i];
            repeat (3) @(posedge i_clk_sys);
            @(posedge i_clk_sys) i_spi_sclk <= 1'b1;
            if (i < 8) rb[i] = o_spi_sdo;
            repeat (3) @(posedge i_clk_sys);
        end
        @(posedge i_clk_sys) i_spi_sclk <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        i_spi_cs_n <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
    endtask : spi

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        spi(1'b0, a, d);
    endtask : wr

    task automatic rd(input logic [14:0] a, input logic [7:0] exp, input string what);
        spi(1'b1, a, 8'h00);
        chk_reg(rb, exp, what);
    endtask : rd

    task automatic stream(input int n_per);
        lim = n_per;
        run = 1'b1;
        for (int k = 0; k < 8000 && nper < lim; k++) @(posedge i_clk_sys);
        chk_val(13'(nper >= lim), 13'h0001, "period count");
        repeat (10) @(posedge i_clk_sys);
        run = 1'b0;
        cmp = 1'b0;
    endtask : stream

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////////
    // Source side: holds a refused word, alternates loud and quiet periods
    always @(posedge i_clk_sys) begin
        logic [31:0] r;
        r = $urandom;
        if (i_sample_valid && o_sample_ready) begin
            m = mag(i_sample);
            run_max = (cnt == 0 || m > run_max) ? m : run_max;
            cnt++;
            if (cnt >= per) begin
                last_peak = run_max;
                cnt = 0;
                nper++;
                if (cmp) exp_q.push_back(run_max);
            end
        end
        if (!i_sample_valid || o_sample_ready) begin
            i_sample_valid <= run && nper < lim && r[31:30] != 2'h0;
            i_sample <= (nper == 0 && cnt == 0) ? 14'h2000 : (nper % 2 == 1)
                ? {{7{r[6]}}, r[6:0]} : r[13:0];
        end
        if (o_sample_valid && i_sample_ready) chk_val(13'(o_sample[1:0]), 13'h0000, "spare bits");
        if (done && cmp) begin
            nfr++;
            chk_val(13'(f_ok), 13'h0001, "start bits");
            if (exp_q.size() != 0) chk_val(f_peak, exp_q.pop_front(), "frame peak");
        end
        cyc++;
        if (cyc == LIMIT) begin
            fails++;
            print_verdict();
        end
    end

    initial begin
        i_reset_n = 1'b0; i_spi_sclk = 1'b0; i_spi_cs_n = 1'b1; i_spi_sdi = 1'b0;
        i_sample = 14'h0000; i_sample_valid = 1'b0; stall_en = 1'b0; run = 1'b0; cmp = 1'b0;
        fails = 0; check_count = 0; cyc = 0; cnt = 0; per = 30; nper = 0; lim = 0; nfr = 0;
        run_max = 13'h0000; last_peak = 13'h0000;
        void'($urandom(79151));
        repeat (2) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        rd(apsm_pkg::ADDR_MON_CTRL, 8'h00, "control reset");
        wr(apsm_pkg::ADDR_PERIOD_0, 8'hAB);
        wr(apsm_pkg::ADDR_PERIOD_1, 8'hCD);
        wr(apsm_pkg::ADDR_PERIOD_2, 8'hEF);
        rd(apsm_pkg::ADDR_PERIOD_0, 8'hAB, "period low");
        rd(apsm_pkg::ADDR_PERIOD_1, 8'hCD, "period mid");
        rd(apsm_pkg::ADDR_PERIOD_2, 8'hEF, "period high");
        wr(apsm_pkg::ADDR_PERIOD_0, 8'h1E);
        wr(apsm_pkg::ADDR_PERIOD_1, 8'h00);
        wr(apsm_pkg::ADDR_PERIOD_2, 8'h00);
        wr(apsm_pkg::ADDR_LINK_EN_A, 8'h03);
        wr(apsm_pkg::ADDR_LINK_EN_B, 8'h02);
        wr(apsm_pkg::ADDR_LINK_CFG_1, 8'h05);
        wr(apsm_pkg::ADDR_LINK_CFG_2, 8'h3C);
        wr(apsm_pkg::ADDR_LINK_CFG_3, 8'h01);
        rd(apsm_pkg::ADDR_LINK_CFG_2, 8'h3C, "link config");
        wr(apsm_pkg::ADDR_HOLD_LO, 8'hFF);
        rd(apsm_pkg::ADDR_HOLD_LO, 8'h00, "read-only hold");
        rd(15'h0300, 8'h00, "unmapped");
        cmp = 1'b1;
        stall_en = 1'b1;
        wr(apsm_pkg::ADDR_MON_CTRL, 8'h02);
        stream(8);
        chk_val(13'(nfr >= 7), 13'h0001, "frame count");
        rd(apsm_pkg::ADDR_HOLD_LO, last_peak[7:0], "hold low");
        rd(apsm_pkg::ADDR_HOLD_HI, {3'h0, last_peak[12:8]}, "hold high");
        wr(apsm_pkg::ADDR_MON_CTRL, 8'h00);
        rd(apsm_pkg::ADDR_HOLD_LO, 8'h00, "hold cleared");
        rd(apsm_pkg::ADDR_HOLD_HI, 8'h00, "hold cleared");
        wr(apsm_pkg::ADDR_PERIOD_0, 8'h01);
        per = 1;
        nper = 0;
        cnt = 0;
        wr(apsm_pkg::ADDR_MON_CTRL, 8'h02);
        stream(6);
        rd(apsm_pkg::ADDR_HOLD_LO, last_peak[7:0], "single sample period");
        rd(apsm_pkg::ADDR_HOLD_HI, {3'h0, last_peak[12:8]}, "single sample period");
        print_verdict();
    end
endmodule : adc_peak_signal_monitor_tb
